/* File: rtl/cmsf_regs.sv */
// Register slice: misc control (RW), system status (RO), fault status (RO).
// Assumes the serial-bus front end and the charger core share sys_clk.
`timescale 1ns/1ps
module cmsf_regs #(
    parameter logic [31:0] WD_BASE_CYCLES = 32'(cmsf_pkg::WD_BASE_S * cmsf_pkg::CLK_HZ) // 40 s in cycles
) (
    input wire logic sys_clk, // Core clock, 25 MHz
    input wire logic rst_n, // Async reset, active low
    input wire logic [7:0] regAddr, // Register address
    input wire logic regWrite, // Write strobe, one cycle
    input wire logic [7:0] regWdata, // Write data
    output logic [7:0] regRdata, // Read data, registered
    input wire logic hostAccess, // Any valid host transaction, kicks watchdog
    input wire logic [1:0] wdSetting, // Watchdog period select
    input wire logic detectDone, // Source detection finished, pulse
    input wire logic [1:0] inputSourceStatus, // Detected input source
    input wire logic [1:0] chargeState, // Charge phase
    input wire logic inputVoltageRegulation, // Input voltage loop active
    input wire logic inputCurrentRegulation, // Input current loop active
    input wire logic inputGood, // Input judged good
    input wire logic thermalRegulation, // Thermal loop active
    input wire logic minSystemReg, // Held at minimum system voltage
    input wire logic boostFault, // Boost overload or overvoltage
    input wire logic [1:0] chargeFaultCode, // Charge fault code
    input wire logic batteryOvervoltage, // Battery overvoltage
    input wire logic [2:0] thermistorFaultCode, // Thermistor band code
    input wire logic [9:0] chargeVoltageTargetMv, // Programmed target, mV offset
    input wire logic safetyTick, // Normal-rate safety timer tick
    output logic forceSourceDetect, // Run data-line detection
    output logic batterySwitchOff, // Force battery path switch off
    output logic [9:0] chargeVoltageTarget, // Effective target, registered
    output logic safetyTimerAdvance, // Safety timer advance pulse
    output logic watchdogExpired, // Watchdog fault flag
    output logic intPulse // Interrupt request pulse
);
    // ------------------------------------------------------------
    // Misc control register
    // ------------------------------------------------------------
    logic [7:0] misc_q;
    logic [7:0] misc_d;
    wire miscWr = regWrite && (regAddr == cmsf_pkg::MISC_OFFSET);
    always_comb begin
        misc_d = misc_q;
        if (miscWr) begin
            misc_d = regWdata;
        end
        // Set from host beats clear by hardware in the same cycle
        if (detectDone && !miscWr) begin
            misc_d[cmsf_pkg::FORCE_DETECT_BIT] = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_q <= cmsf_pkg::MISC_RESET;
        end else begin
            misc_q <= misc_d;
        end
    end
    // Bits 3 and 2 stored as written; host keeps them 1 and 0
    assign forceSourceDetect = misc_q[cmsf_pkg::FORCE_DETECT_BIT];
    assign batterySwitchOff = misc_q[cmsf_pkg::SWITCH_OFF_BIT];
    // ------------------------------------------------------------
    // Status sampling
    // ------------------------------------------------------------
    logic [7:0] status_q;
    logic [6:0] faultLow_q;
    wire [7:0] statusNow = {inputSourceStatus, chargeState,
        inputVoltageRegulation | inputCurrentRegulation,
        inputGood, thermalRegulation, minSystemReg};
    wire [6:0] faultNow = {boostFault, chargeFaultCode, batteryOvervoltage, thermistorFaultCode};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 8'h00;
            faultLow_q <= 7'h00;
        end else begin
            status_q <= statusNow;
            faultLow_q <= faultNow;
        end
    end
    // ------------------------------------------------------------
    // Host watchdog
    // ------------------------------------------------------------
    logic [31:0] wdCount_q;
    logic wdFault_q;
    wire [31:0] wdLimit = (wdSetting == 2'h1) ? WD_BASE_CYCLES :
                          (wdSetting == 2'h2) ? (WD_BASE_CYCLES << 1) :
                          (WD_BASE_CYCLES << 2);
    wire wdOn = (wdSetting != cmsf_pkg::WD_OFF);
    wire wdHit = wdOn && !hostAccess && (wdCount_q >= wdLimit - 32'h1);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdCount_q <= 32'h0;
            wdFault_q <= 1'b0;
        end else begin
            if (!wdOn || hostAccess || wdHit) begin
                wdCount_q <= 32'h0;
            end else begin
                wdCount_q <= wdCount_q + 32'h1;
            end
            // A host access in the same cycle wins over expiry and clears the fault
            if (wdHit) begin
                wdFault_q <= 1'b1;
            end else if (hostAccess) begin
                wdFault_q <= 1'b0;
            end
        end
    end
    assign watchdogExpired = wdFault_q;
    // ------------------------------------------------------------
    // Read path; status and fault writes are dropped
    // ------------------------------------------------------------
    wire [7:0] faultReg = {wdFault_q, faultLow_q};
    wire [7:0] rdMux = (regAddr == cmsf_pkg::MISC_OFFSET) ? misc_q :
                       (regAddr == cmsf_pkg::STATUS_OFFSET) ? status_q :
                       (regAddr == cmsf_pkg::FAULT_OFFSET) ? faultReg : 8'h00;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= rdMux;
        end
    end
    // ------------------------------------------------------------
    // Safety timer rate and warm-band target
    // ------------------------------------------------------------
    logic halfPhase_q;
    wire slowed = misc_q[cmsf_pkg::STRETCH_BIT] &&
                  (inputVoltageRegulation || inputCurrentRegulation || thermalRegulation);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            halfPhase_q <= 1'b0;
        end else if (safetyTick) begin
            halfPhase_q <= ~halfPhase_q;
        end
    end
    assign safetyTimerAdvance = safetyTick && (!slowed || halfPhase_q);
    wire warmDrop = (thermistorFaultCode == cmsf_pkg::THERM_WARM) && misc_q[cmsf_pkg::WARM_VOLT_BIT];
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chargeVoltageTarget <= 10'h000;
        end else begin
            chargeVoltageTarget <= warmDrop ? chargeVoltageTargetMv - cmsf_pkg::WARM_DROP_MV
                                            : chargeVoltageTargetMv;
        end
    end
    // ------------------------------------------------------------
    // Interrupt on new faults other than thermistor faults
    // ------------------------------------------------------------
    logic [7:0] faultPrev_q;
    wire chgEvent = (faultLow_q[5:4] != cmsf_pkg::CHG_FAULT_NORMAL) &&
                    (faultLow_q[5:4] != faultPrev_q[5:4]);
    wire wdNew = faultReg[7] && !faultPrev_q[7];
    wire boostNew = faultReg[6] && !faultPrev_q[6];
    wire batNew = faultReg[3] && !faultPrev_q[3];
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            faultPrev_q <= 8'h00;
            intPulse <= 1'b0;
        end else begin
            faultPrev_q <= faultReg;
            intPulse <= wdNew || boostNew ||
                        (chgEvent && misc_q[cmsf_pkg::CHG_MASK_BIT]) ||
                        (batNew && misc_q[cmsf_pkg::BAT_MASK_BIT]);
        end
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_detectEnd;
        forceSourceDetect ##0 (detectDone && !miscWr);
    endsequence
    a_detect_self_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_detectEnd |=> !forceSourceDetect) else $error("force detect not cleared");
    a_switch_follows_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (miscWr && regWdata[5]) |=> batterySwitchOff) else $error("switch off not applied");
    a_timer_half_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (safetyTick && slowed && !halfPhase_q) |-> !safetyTimerAdvance) else $error("timer not slowed");
    a_warm_target: assert property (@(posedge sys_clk) disable iff (!rst_n)
        warmDrop |=> chargeVoltageTarget == $past(chargeVoltageTargetMv) - 10'd200) else $error("warm target");
    a_charge_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!misc_q[1] && !wdNew && !boostNew && !batNew) |=> !intPulse) else $error("masked charge int");
    a_battery_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (batNew && misc_q[0]) |=> intPulse) else $error("battery int missing");
    a_regulation_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (inputVoltageRegulation || inputCurrentRegulation) |=> status_q[3]) else $error("reg status");
    a_status_readonly: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (regWrite && regAddr == 8'h08) |=> status_q == $past(statusNow)) else $error("status written");
    a_watchdog_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wdHit |=> watchdogExpired && faultReg[7]) else $error("watchdog fault missing");

    // ------------------------------------------------------------
    // Control register checks
    // ------------------------------------------------------------
    sequence s_miscWrite;
        miscWr;
    endsequence
    sequence s_outOfReset;
        rst_n;
    endsequence
    sequence s_hostKick;
        hostAccess && wdOn;
    endsequence

    a_misc_stores_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_miscWrite |=> misc_q == $past(regWdata))
        else $error("misc write lost");
    a_switch_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (miscWr && !regWdata[cmsf_pkg::SWITCH_OFF_BIT]) |=> !batterySwitchOff)
        else $error("switch off stuck");
    a_detect_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (miscWr && regWdata[cmsf_pkg::FORCE_DETECT_BIT]) |=> forceSourceDetect)
        else $error("force detect not started");
    a_reset_misc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> misc_q == cmsf_pkg::MISC_RESET)
        else $error("misc reset value");
    a_timer_full_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (safetyTick && !slowed) |-> safetyTimerAdvance)
        else $error("timer slowed wrongly");
    a_target_normal: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_outOfReset and !warmDrop) |=> chargeVoltageTarget == $past(chargeVoltageTargetMv))
        else $error("normal target");

    // ------------------------------------------------------------
    // Status and fault sampling checks
    // ------------------------------------------------------------
    a_status_sample: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_outOfReset |=> status_q == $past(statusNow))
        else $error("status not sampled");
    a_fault_sample: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_outOfReset |=> faultLow_q == $past(faultNow))
        else $error("fault not sampled");
    a_source_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_outOfReset |=> status_q[7:6] == $past(inputSourceStatus))
        else $error("source field");
    a_charge_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_outOfReset |=> status_q[5:4] == $past(chargeState))
        else $error("charge state field");
    a_input_good: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_outOfReset |=> status_q[2] == $past(inputGood))
        else $error("input good bit");
    a_thermal_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_outOfReset |=> status_q[1] == $past(thermalRegulation))
        else $error("thermal bit");
    a_min_system: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_outOfReset |=> status_q[0] == $past(minSystemReg))
        else $error("min system bit");
    a_regulation_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rst_n && !inputVoltageRegulation && !inputCurrentRegulation) |=> !status_q[3])
        else $error("reg status idle");
    a_fault_readonly: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (regWrite && regAddr == cmsf_pkg::FAULT_OFFSET) |=> faultLow_q == $past(faultNow))
        else $error("fault written");
    a_read_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (regAddr == cmsf_pkg::STATUS_OFFSET) |=> regRdata == $past(status_q))
        else $error("status read");
    a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (regAddr != cmsf_pkg::MISC_OFFSET && regAddr != cmsf_pkg::STATUS_OFFSET &&
         regAddr != cmsf_pkg::FAULT_OFFSET) |=> regRdata == 8'h00)
        else $error("unmapped read");

    // ------------------------------------------------------------
    // Watchdog and interrupt checks
    // ------------------------------------------------------------
    a_watchdog_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!wdOn && !wdFault_q) |=> !wdFault_q)
        else $error("watchdog ran while off");
    a_watchdog_kick: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_hostKick |=> wdCount_q == 32'h0)
        else $error("watchdog not restarted");
    a_watchdog_int: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wdNew |=> intPulse)
        else $error("watchdog int missing");
    a_boost_int: assert property (@(posedge sys_clk) disable iff (!rst_n)
        boostNew |=> intPulse)
        else $error("boost int missing");
    a_charge_int: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (chgEvent && misc_q[cmsf_pkg::CHG_MASK_BIT]) |=> intPulse)
        else $error("charge int missing");
    a_battery_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!misc_q[cmsf_pkg::BAT_MASK_BIT] && !wdNew && !boostNew && !chgEvent) |=> !intPulse)
        else $error("masked battery int");
endmodule

/* File: rtl/cmsf_pkg.sv */
// Package for the charger misc control, system status and fault register slice.
// Assumes a byte-wide register port driven by the serial-bus front end.
package cmsf_pkg;
    // ------------------------------------------------------------
    // Register offsets and reset value
    // ------------------------------------------------------------
    localparam logic [7:0] MISC_OFFSET = 8'h07;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] FAULT_OFFSET = 8'h09;
    localparam logic [7:0] MISC_RESET = 8'h4b;
    // ------------------------------------------------------------
    // Field positions of the misc control register
    // ------------------------------------------------------------
    localparam int FORCE_DETECT_BIT = 7;
    localparam int STRETCH_BIT = 6;
    localparam int SWITCH_OFF_BIT = 5;
    localparam int WARM_VOLT_BIT = 4;
    localparam int RSVD_ONE_BIT = 3;
    localparam int RSVD_ZERO_BIT = 2;
    localparam int CHG_MASK_BIT = 1;
    localparam int BAT_MASK_BIT = 0;
    // ------------------------------------------------------------
    // Field codes and timing
    // ------------------------------------------------------------
    localparam logic [1:0] CHG_FAULT_NORMAL = 2'h0;
    localparam logic [2:0] THERM_NORMAL = 3'h0;
    localparam logic [2:0] THERM_WARM = 3'h2;
    localparam logic [9:0] WARM_DROP_MV = 10'd200;
    localparam int WD_BASE_S = 40;
    localparam int CLK_HZ = 25000000;
    localparam logic [1:0] WD_OFF = 2'h0;
endpackage

/* File: verif/cmsf_core_model.sv */
// Charger-core stand-in: answers a forced source detection with a done pulse.
// Assumes it shares sys_clk and rst_n with the register slice.
`timescale 1ns/1ps
module cmsf_core_model #(
    parameter int DETECT_CYCLES = 20 // Detection length, plain default
) (
    input wire logic sys_clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic forceSourceDetect, // Detection request level
    output logic detectDone // One-cycle completion pulse
);
    int cnt;
    // Pulse once per request; a held request restarts the count
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            detectDone <= 1'b0;
        end else begin
            detectDone <= (cnt == DETECT_CYCLES);
            cnt <= (forceSourceDetect && cnt <= DETECT_CYCLES) ? cnt + 1 : 0;
        end
    end
endmodule

/* File: verif/charger_misc_status_fault_regs_tb.sv */
// Self-checking bench for the misc control, status and fault register slice.
// Assumes a 25 MHz core clock and a watchdog base shortened to 100 cycles.
`timescale 1ns/1ps
module charger_misc_status_fault_regs_tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, hostAccess = 1'b0, safetyTick = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, v;
    logic [1:0] wdSetting = 2'h0, inputSourceStatus = 2'h0, chargeState = 2'h0, chargeFaultCode = 2'h0;
    logic inputVoltageRegulation = 1'b0, inputCurrentRegulation = 1'b0, inputGood = 1'b0;
    logic thermalRegulation = 1'b0, minSystemReg = 1'b0, boostFault = 1'b0, batteryOvervoltage = 1'b0;
    logic [2:0] thermistorFaultCode = 3'h0;
    logic [9:0] chargeVoltageTargetMv = 10'd500, chargeVoltageTarget;
    logic detectDone, forceSourceDetect, batterySwitchOff, safetyTimerAdvance, watchdogExpired, intPulse;
    logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
    int errors = 0, samplesChecked = 0, n, k;
    always #20 sys_clk = ~sys_clk;
    cmsf_regs #(.WD_BASE_CYCLES(32'd100)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .hostAccess(hostAccess),
        .wdSetting(wdSetting), .detectDone(detectDone), .inputSourceStatus(inputSourceStatus),
        .chargeState(chargeState), .inputVoltageRegulation(inputVoltageRegulation),
        .inputCurrentRegulation(inputCurrentRegulation), .inputGood(inputGood),
        .thermalRegulation(thermalRegulation), .minSystemReg(minSystemReg), .boostFault(boostFault),
        .chargeFaultCode(chargeFaultCode), .batteryOvervoltage(batteryOvervoltage),
        .thermistorFaultCode(thermistorFaultCode), .chargeVoltageTargetMv(chargeVoltageTargetMv),
        .safetyTick(safetyTick), .forceSourceDetect(forceSourceDetect), .batterySwitchOff(batterySwitchOff),
        .chargeVoltageTarget(chargeVoltageTarget), .safetyTimerAdvance(safetyTimerAdvance),
        .watchdogExpired(watchdogExpired), .intPulse(intPulse));
    cmsf_core_model #(.DETECT_CYCLES(20)) core_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .forceSourceDetect(forceSourceDetect), .detectDone(detectDone));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    // Every register write counts as host traffic and kicks the watchdog
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        hostAccess = 1'b1;
        step(1);
        regWrite = 1'b0;
        hostAccess = 1'b0;
        step(1);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        regAddr = a;
        step(2);
        chk(regRdata, exp);
    endtask
    function automatic logic [7:0] statExp();
        return {inputSourceStatus, chargeState, inputVoltageRegulation | inputCurrentRegulation,
            inputGood, thermalRegulation, minSystemReg};
    endfunction
    function automatic logic [7:0] faultExp(input logic wd);
        return {wd, boostFault, chargeFaultCode, batteryOvervoltage, thermistorFaultCode};
    endfunction
    // Eight ticks; stretch halves the advances only while a loop regulates
    task automatic ticks(output int cnt);
        cnt = 0;
        repeat (8) begin
            safetyTick = 1'b1;
            #5 cnt += (safetyTimerAdvance === 1'b1);
            step(1);
            safetyTick = 1'b0;
            step(1);
        end
    endtask
    initial begin
        void'($urandom(32'ha916));
        step(12);
        rst_n = 1'b1;
        step(1);
        rchk(8'h07, 8'h4b);
        chk({forceSourceDetect, batterySwitchOff}, 0);
        repeat (12) begin
            {inputSourceStatus, chargeState, inputVoltageRegulation, inputCurrentRegulation} = 6'($urandom);
            {inputGood, thermalRegulation, minSystemReg, boostFault, batteryOvervoltage} = 5'($urandom);
            chargeFaultCode = 2'($urandom);
            thermistorFaultCode = codes[$urandom % 5];
            rchk(8'h08, statExp());
            rchk(8'h09, faultExp(1'b0));
            wr(8'h08, 8'($urandom));
            wr(8'h09, 8'($urandom));
            rchk(8'h08, statExp());
            rchk(8'h09, faultExp(1'b0));
        end
        rchk(8'h0c, 8'h00);
        {boostFault, batteryOvervoltage, chargeFaultCode, thermistorFaultCode} = 7'h00;
        {inputVoltageRegulation, inputCurrentRegulation, thermalRegulation} = 3'h0;
        step(4);
        for (int i = 0; i < 8; i++) begin
            wr(8'h07, 8'h48 | 8'(i[1:0]));
            if (i[2]) batteryOvervoltage = 1'b1;
            else chargeFaultCode = 2'h3;
            n = 0;
            repeat (5) begin
                step(1);
                n += (intPulse === 1'b1);
            end
            chk(n, i[2] ? i[0] : i[1]);
            batteryOvervoltage = 1'b0;
            chargeFaultCode = 2'h0;
            step(5);
        end
        boostFault = 1'b1;
        n = 0;
        repeat (5) begin
            step(1);
            n += (intPulse === 1'b1);
        end
        chk(n, 1);
        boostFault = 1'b0;
        wr(8'h07, 8'h48);
        ticks(n);
        chk(n, 8);
        thermalRegulation = 1'b1;
        ticks(n);
        chk(n, 4);
        wr(8'h07, 8'h08);
        ticks(n);
        chk(n, 8);
        thermalRegulation = 1'b0;
        wr(8'h07, 8'h38);
        thermistorFaultCode = 3'h2;
        rchk(8'h07, 8'h38);
        chk({batterySwitchOff, chargeVoltageTarget}, {1'b1, 10'd300});
        wr(8'h07, 8'h08);
        step(2);
        chk({batterySwitchOff, chargeVoltageTarget}, {1'b0, 10'd500});
        wr(8'h07, 8'hc8);
        chk(forceSourceDetect, 1);
        for (k = 0; k < 100 && forceSourceDetect !== 1'b0; k++) step(1);
        if (k == 100) begin
            errors++;
        end
        rchk(8'h07, 8'h48);
        thermistorFaultCode = 3'h0;
        wdSetting = 2'h1;
        wr(8'h07, 8'h48);
        step(90);
        chk(watchdogExpired, 0);
        step(20);
        chk(watchdogExpired, 1);
        rchk(8'h09, faultExp(1'b1));
        wdSetting = 2'h2;
        wr(8'h07, 8'h48);
        step(190);
        chk(watchdogExpired, 0);
        step(20);
        chk(watchdogExpired, 1);
        close_out();
    end
endmodule
